// ---- rtl/pao_pkg.sv ----
// Package for the port A alternative function override block
package pao_pkg;
	localparam int PORT_WIDTH = 8;

	// Pin positions of alternative functions
	localparam int PIN_SPI_SCK_DEF   = 4;
	localparam int PIN_SPI_MISO_DEF  = 5;
	localparam int PIN_SPI_MOSI_DEF  = 6;
	localparam int PIN_SPI_SS_DEF    = 7;
	localparam int PIN_SPI_MISO_ALT  = 0;
	localparam int PIN_SPI_MOSI_ALT  = 1;
	localparam int PIN_SPI_SS_ALT    = 2;
	localparam int PIN_SPI_SCK_ALT   = 3;
	localparam int PIN_SER0_TX_DEF   = 1;
	localparam int PIN_SER0_RX       = 2;
	localparam int PIN_SER0_TX_ALT   = 7;
	localparam int PIN_SER0_XCK      = 3;
	localparam int PIN_SER1_RX       = 4;
	localparam int PIN_SER1_TX       = 5;
	localparam int PIN_SER1_XCK      = 6;
	localparam int PIN_I2C_SCL       = 4;
	localparam int PIN_I2C_SDA       = 6;
	localparam int PIN_TIMER_CMP_LO  = 1;
	localparam int NUM_TIMER_CMP     = 7;
	localparam int PIN_TIMER0_CLK    = 3;
	localparam int PIN_TIMER1_CLK    = 4;
	localparam int PIN_TIMER2_CLK    = 5;
	localparam int PIN_CAPTURE       = 7;
	localparam int PIN_CMP0_OUT      = 5;
	localparam int PIN_CMP1_OUT      = 6;

	localparam logic [PORT_WIDTH-1:0] PORT_RESET = 8'h00;

	// One override group per pin set, one bit per pin
	typedef struct packed {
		logic [PORT_WIDTH-1:0] pullup_override_en;
		logic [PORT_WIDTH-1:0] pullup_override_val;
		logic [PORT_WIDTH-1:0] dir_override_en;
		logic [PORT_WIDTH-1:0] dir_override_val;
		logic [PORT_WIDTH-1:0] value_override_en;
		logic [PORT_WIDTH-1:0] value_override_val;
		logic [PORT_WIDTH-1:0] toggle_override_en;
		logic [PORT_WIDTH-1:0] input_en_override_en;
		logic [PORT_WIDTH-1:0] input_en_override_val;
	} pao_override_type;

	// Pad controls for the whole port
	typedef struct packed {
		logic [PORT_WIDTH-1:0] pullup_en;
		logic [PORT_WIDTH-1:0] drive_en;
		logic [PORT_WIDTH-1:0] drive_val;
		logic [PORT_WIDTH-1:0] input_en;
	} pao_pad_type;

	// Port register write bundle, strobes shared by the port
	typedef struct packed {
		logic                  wr_pullup;
		logic                  wr_dir;
		logic                  wr_out;
		logic                  wr_toggle;
		logic [PORT_WIDTH-1:0] wdata;
	} pao_regwr_type;
endpackage

// ---- rtl/pao_pin_mux.sv ----
// Override selection for one port pin
module pao_pin_mux (
	input  wire logic i_pullup_bit,
	input  wire logic i_direction_bit,
	input  wire logic i_output_bit,
	input  wire logic i_sleep_clamp,
	input  wire logic i_pu_oe,
	input  wire logic i_pu_ov,
	input  wire logic i_dd_oe,
	input  wire logic i_dd_ov,
	input  wire logic i_pv_oe,
	input  wire logic i_pv_ov,
	input  wire logic i_die_oe,
	input  wire logic i_die_ov,
	output logic      o_pullup_en,
	output logic      o_drive_en,
	output logic      o_drive_val,
	output logic      o_input_en
);
	assign o_pullup_en = i_pu_oe ? i_pu_ov : (i_pullup_bit == 1'b1);
	assign o_drive_en  = i_dd_oe ? i_dd_ov : i_direction_bit;
	assign o_drive_val = o_drive_en & (i_pv_oe ? i_pv_ov : i_output_bit);
	assign o_input_en  = i_die_oe ? i_die_ov : ~i_sleep_clamp;
endmodule

// ---- rtl/pao_sync2.sv ----
// Two flip-flop synchroniser for one bit
module pao_sync2 (
	input  wire logic i_sys_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_clk_en,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta   <= 1'b0;
			o_sync <= 1'b0;
		end else if (i_clk_en) begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule

// ---- rtl/pao_port_a.sv ----
// Port A registers, pin override muxing and peripheral routing
// How it works
// - Pull-up override enable high: pull-up follows override value.
// - No pull-up override: pull-up on when pull-up register bit is one.
// - Direction override enable high: driver follows override value.
// - No direction override: driver enabled from direction register bit.
// - Value override high while driving: pin takes value override.
// - No value override while driving: pin takes output register bit.
// - Toggle override enable high inverts the output register bit.
// - Input-enable override high: input enable follows override value.
// - No input override: input enabled unless sleep clamp active.
// - Peripherals see pad input before the port read synchroniser.
// - Register strobes shared per port; other overrides per pin.
// - SPI default pins: clock 4, in 5, out 6, select 7.
// - SPI alternative pins: in 0, out 1, select 2, clock 3.
// - Serial 0: transmit 1, receive 2, alt transmit 7, clock 3.
// - Serial 1: receive 4, transmit 5, transfer clock 6.
// - Timer compare channels 0 to 6 on bits 1 to 7.
// - Each port bit n is pin change source n.
// - Timer clocks on bits 3, 4, 5; capture input bit 7.
// - Comparator 0 output on bit 5, comparator 1 on bit 6.
module pao_port_a
	import pao_pkg::*;
(
	input  wire logic                           i_sys_clk,
	input  wire logic                           i_sys_rst,
	input  wire logic                           i_clk_en,
	input  wire logic                           i_sleep_clamp,
	input  wire pao_pkg::pao_regwr_type         i_regwr,
	input  wire pao_pkg::pao_override_type      i_ovr,
	input  wire logic [pao_pkg::PORT_WIDTH-1:0] i_pad_in,
	output pao_pkg::pao_pad_type                o_pad,
	output logic [pao_pkg::PORT_WIDTH-1:0]      o_pin_pullup_bit,
	output logic [pao_pkg::PORT_WIDTH-1:0]      o_pin_direction_bit,
	output logic [pao_pkg::PORT_WIDTH-1:0]      o_pin_output_bit,
	output logic [pao_pkg::PORT_WIDTH-1:0]      o_pin_read,
	output logic [pao_pkg::PORT_WIDTH-1:0]      o_pin_digital_in,
	output logic [pao_pkg::PORT_WIDTH-1:0]      o_pin_change_src,
	output logic                                o_spi_sck_def_in,
	output logic                                o_spi_mosi_def_in,
	output logic                                o_spi_ss_def_in,
	output logic                                o_spi_miso_def_in,
	output logic                                o_spi_sck_alt_in,
	output logic                                o_spi_mosi_alt_in,
	output logic                                o_spi_ss_alt_in,
	output logic                                o_spi_miso_alt_in,
	output logic                                o_serial0_rx,
	output logic                                o_serial0_xfer_clk,
	output logic                                o_serial1_rx,
	output logic                                o_serial1_xfer_clk,
	output logic                                o_i2c_scl_in,
	output logic                                o_i2c_sda_in,
	output logic                                o_timer0_ext_clk,
	output logic                                o_timer1_ext_clk,
	output logic                                o_timer2_ext_clk,
	output logic                                o_capture_input,
	output logic [pao_pkg::PORT_WIDTH-1:0]      o_pin_digital_en
);
	import pao_pkg::*;

	logic [PORT_WIDTH-1:0] pin_pullup_bit;
	logic [PORT_WIDTH-1:0] pin_direction_bit;
	logic [PORT_WIDTH-1:0] pin_output_bit;
	logic [PORT_WIDTH-1:0] next_output_bit;
	logic [PORT_WIDTH-1:0] pad_pullup_en;
	logic [PORT_WIDTH-1:0] pad_drive_en;
	logic [PORT_WIDTH-1:0] pad_drive_val;
	logic [PORT_WIDTH-1:0] pad_input_en;
	logic [PORT_WIDTH-1:0] gated_in;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_pullup_bit <= PORT_RESET;
		end else if (i_clk_en && i_regwr.wr_pullup) begin
			pin_pullup_bit <= i_regwr.wdata;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_direction_bit <= PORT_RESET;
		end else if (i_clk_en && i_regwr.wr_dir) begin
			pin_direction_bit <= i_regwr.wdata;
		end
	end

	always_comb begin
		next_output_bit = pin_output_bit;
		if (i_regwr.wr_out) begin
			next_output_bit = i_regwr.wdata;
		end
		if (i_regwr.wr_toggle) begin
			next_output_bit = next_output_bit ^ i_regwr.wdata;
		end
		// Per-pin toggle is applied last so it inverts the result of any register write
		next_output_bit = next_output_bit ^ i_ovr.toggle_override_en;
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_output_bit <= PORT_RESET;
		end else if (i_clk_en) begin
			pin_output_bit <= next_output_bit;
		end
	end

	for (genvar n = 0; n < PORT_WIDTH; n++) begin : g_pin
		pao_pin_mux u_mux (
			.i_pullup_bit    (pin_pullup_bit[n]),
			.i_direction_bit (pin_direction_bit[n]),
			.i_output_bit    (pin_output_bit[n]),
			.i_sleep_clamp   (i_sleep_clamp),
			.i_pu_oe         (i_ovr.pullup_override_en[n]),
			.i_pu_ov         (i_ovr.pullup_override_val[n]),
			.i_dd_oe         (i_ovr.dir_override_en[n]),
			.i_dd_ov         (i_ovr.dir_override_val[n]),
			.i_pv_oe         (i_ovr.value_override_en[n]),
			.i_pv_ov         (i_ovr.value_override_val[n]),
			.i_die_oe        (i_ovr.input_en_override_en[n]),
			.i_die_ov        (i_ovr.input_en_override_val[n]),
			.o_pullup_en     (pad_pullup_en[n]),
			.o_drive_en      (pad_drive_en[n]),
			.o_drive_val     (pad_drive_val[n]),
			.o_input_en      (pad_input_en[n])
		);

		// Port read path gets its own synchroniser
		pao_sync2 u_sync (
			.i_sys_clk (i_sys_clk),
			.i_sys_rst (i_sys_rst),
			.i_clk_en  (i_clk_en),
			.i_async   (gated_in[n]),
			.o_sync    (o_pin_read[n])
		);
	end

	// Clamp to ground when the input is disabled
	assign gated_in = i_pad_in & pad_input_en;

	assign o_pad.pullup_en = pad_pullup_en;
	assign o_pad.drive_en  = pad_drive_en;
	assign o_pad.drive_val = pad_drive_val;
	assign o_pad.input_en  = pad_input_en;

	assign o_pin_pullup_bit    = pin_pullup_bit;
	assign o_pin_direction_bit = pin_direction_bit;
	assign o_pin_output_bit    = pin_output_bit;
	assign o_pin_digital_en    = pad_input_en;

	assign o_pin_digital_in = gated_in;
	assign o_pin_change_src = gated_in;

	assign o_spi_sck_def_in  = gated_in[PIN_SPI_SCK_DEF];
	assign o_spi_miso_def_in = gated_in[PIN_SPI_MISO_DEF];
	assign o_spi_mosi_def_in = gated_in[PIN_SPI_MOSI_DEF];
	assign o_spi_ss_def_in   = gated_in[PIN_SPI_SS_DEF];
	assign o_spi_miso_alt_in = gated_in[PIN_SPI_MISO_ALT];
	assign o_spi_mosi_alt_in = gated_in[PIN_SPI_MOSI_ALT];
	assign o_spi_ss_alt_in   = gated_in[PIN_SPI_SS_ALT];
	assign o_spi_sck_alt_in  = gated_in[PIN_SPI_SCK_ALT];
	assign o_serial0_rx       = gated_in[PIN_SER0_RX];
	assign o_serial0_xfer_clk = gated_in[PIN_SER0_XCK];
	assign o_serial1_rx       = gated_in[PIN_SER1_RX];
	assign o_serial1_xfer_clk = gated_in[PIN_SER1_XCK];
	assign o_i2c_scl_in = gated_in[PIN_I2C_SCL];
	assign o_i2c_sda_in = gated_in[PIN_I2C_SDA];
	assign o_timer0_ext_clk = gated_in[PIN_TIMER0_CLK];
	assign o_timer1_ext_clk = gated_in[PIN_TIMER1_CLK];
	assign o_timer2_ext_clk = gated_in[PIN_TIMER2_CLK];
	assign o_capture_input  = gated_in[PIN_CAPTURE];
endmodule

// ---- verification/pao_periph_model.sv ----
// Peripheral side model: override source and own input synchroniser
module pao_periph_model
	import pao_pkg::*;
(
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_sys_rst,
	input  wire pao_pkg::pao_override_type i_req,
	input  wire logic [7:0]             i_pin_digital_in,
	output pao_pkg::pao_override_type   o_ovr,
	output logic [7:0]                  o_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] meta;

	assign o_ovr = i_req;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta <= 8'h00;
			o_seen <= 8'h00;
		end else begin
			meta <= i_pin_digital_in;
			o_seen <= meta;
		end
	end
endmodule

// ---- verification/pao_port_a_sva.sv ----
// Checker for port A override selection
module pao_port_a_chk
	import pao_pkg::*;
(
	input wire logic                   i_sys_clk,
	input wire logic                   i_sys_rst,
	input wire logic                   i_clk_en,
	input wire logic                   i_sleep_clamp,
	input wire pao_pkg::pao_regwr_type    i_regwr,
	input wire pao_pkg::pao_override_type i_ovr,
	input wire logic [7:0]             i_pad_in,
	input wire pao_pkg::pao_pad_type   o_pad,
	input wire logic [7:0]             o_pin_pullup_bit,
	input wire logic [7:0]             o_pin_direction_bit,
	input wire logic [7:0]             o_pin_output_bit,
	input wire logic [7:0]             o_pin_digital_in,
	input wire logic [7:0]             o_pin_change_src,
	input wire logic                   o_spi_sck_def_in,
	input wire logic                   o_spi_miso_alt_in,
	input wire logic                   o_serial0_rx,
	input wire logic                   o_timer0_ext_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_dir_wr;
		i_clk_en && i_regwr.wr_dir;
	endsequence
	// Register loads would mask the inversion
	sequence s_tog_hold;
		i_clk_en && (|i_ovr.toggle_override_en) && !i_regwr.wr_out
			&& !i_regwr.wr_toggle;
	endsequence

	pullup_sel_a: assert property (o_pad.pullup_en ===
		((i_ovr.pullup_override_en & i_ovr.pullup_override_val)
		| (~i_ovr.pullup_override_en & o_pin_pullup_bit)))
		else $error("pull-up select wrong");
	drive_sel_a: assert property (o_pad.drive_en ===
		((i_ovr.dir_override_en & i_ovr.dir_override_val)
		| (~i_ovr.dir_override_en & o_pin_direction_bit)))
		else $error("drive enable select wrong");
	value_sel_a: assert property (o_pad.drive_val ===
		(o_pad.drive_en
		& ((i_ovr.value_override_en & i_ovr.value_override_val)
		| (~i_ovr.value_override_en & o_pin_output_bit))))
		else $error("drive value select wrong");
	input_sel_a: assert property (o_pad.input_en ===
		((i_ovr.input_en_override_en & i_ovr.input_en_override_val)
		| (~i_ovr.input_en_override_en & {8{~i_sleep_clamp}})))
		else $error("input enable select wrong");
	raw_input_a: assert property (o_pin_digital_in ===
		(i_pad_in & o_pad.input_en) && o_pin_change_src === o_pin_digital_in)
		else $error("peripheral input path wrong");
	pin_route_a: assert property ({o_spi_sck_def_in,
		o_spi_miso_alt_in, o_serial0_rx, o_timer0_ext_clk}
		=== {o_pin_digital_in[4], o_pin_digital_in[0],
		o_pin_digital_in[2], o_pin_digital_in[3]})
		else $error("peripheral pin routing wrong");
	dir_write_a: assert property (s_dir_wr |=>
		o_pin_direction_bit === $past(i_regwr.wdata))
		else $error("direction write lost");
	toggle_inv_a: assert property (s_tog_hold |=> o_pin_output_bit ===
		($past(o_pin_output_bit) ^ $past(i_ovr.toggle_override_en)))
		else $error("toggle override wrong");
	frozen_out_a: assert property (!i_clk_en |=>
		$stable(o_pin_output_bit))
		else $error("output bits moved while frozen");
endmodule

bind pao_port_a pao_port_a_chk u_pao_port_a_chk (.i_sys_clk, .i_sys_rst,
	.i_clk_en, .i_sleep_clamp, .i_regwr, .i_ovr, .i_pad_in, .o_pad,
	.o_pin_pullup_bit, .o_pin_direction_bit, .o_pin_output_bit,
	.o_pin_digital_in, .o_pin_change_src, .o_spi_sck_def_in,
	.o_spi_miso_alt_in, .o_serial0_rx, .o_timer0_ext_clk);

// ---- verification/test_pao_port_a.sv ----
// Testbench for the port A override block
module test_pao_port_a
	import pao_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk, i_sys_rst, i_clk_en, i_sleep_clamp;
	pao_regwr_type i_regwr;
	pao_override_type i_ovr, req;
	pao_pad_type o_pad;
	logic [7:0] i_pad_in, o_pin_pullup_bit, o_pin_direction_bit, seen;
	logic [7:0] o_pin_output_bit, o_pin_digital_in, o_pin_change_src;
	logic [7:0] o_pin_digital_en, o_pin_read;
	logic o_spi_sck_def_in, o_spi_mosi_def_in, o_spi_ss_def_in;
	logic o_spi_miso_def_in, o_spi_sck_alt_in, o_spi_mosi_alt_in;
	logic o_spi_ss_alt_in, o_spi_miso_alt_in, o_serial0_rx, o_serial1_rx;
	logic o_serial0_xfer_clk, o_serial1_xfer_clk, o_i2c_scl_in, o_i2c_sda_in;
	logic o_timer0_ext_clk, o_timer1_ext_clk, o_timer2_ext_clk;
	logic o_capture_input;
	int mismatches, cmp_count;

	pao_port_a u_pao_port_a (.i_sys_clk, .i_sys_rst, .i_clk_en,
		.i_sleep_clamp, .i_regwr, .i_ovr, .i_pad_in, .o_pad, .o_pin_pullup_bit,
		.o_pin_direction_bit, .o_pin_output_bit, .o_pin_read,
		.o_pin_digital_in, .o_pin_change_src, .o_spi_sck_def_in,
		.o_spi_mosi_def_in, .o_spi_ss_def_in, .o_spi_miso_def_in,
		.o_spi_sck_alt_in, .o_spi_mosi_alt_in, .o_spi_ss_alt_in,
		.o_spi_miso_alt_in, .o_serial0_rx, .o_serial0_xfer_clk, .o_serial1_rx,
		.o_serial1_xfer_clk, .o_i2c_scl_in, .o_i2c_sda_in, .o_timer0_ext_clk,
		.o_timer1_ext_clk, .o_timer2_ext_clk, .o_capture_input,
		.o_pin_digital_en);
	pao_periph_model u_pao_periph_model (.i_sys_clk, .i_sys_rst,
		.i_req(req), .i_pin_digital_in(o_pin_digital_in), .o_ovr(i_ovr),
		.o_seen(seen));

	initial begin
		i_sys_clk = 1'h0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_route(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Strobes drop before the next write may start
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		i_regwr = {s, d};
		@(negedge i_sys_clk);
		i_regwr = '0;
		@(negedge i_sys_clk);
	endtask

	task automatic t_reset;
		cmp8(o_pad.pullup_en, 8'h00);
		cmp8(o_pad.drive_en, 8'h00);
		cmp8(o_pad.input_en, 8'hFF);
	endtask
	task automatic t_regs;
		wr(4'h8, 8'h5A);
		wr(4'h6, 8'h0F);
		wr(4'h1, 8'hC3);
		cmp8(o_pin_pullup_bit, 8'h5A);
		cmp8(o_pin_direction_bit, 8'h0F);
		cmp8(o_pad.pullup_en, 8'h5A);
		cmp8(o_pad.drive_en, 8'h0F);
		cmp8(o_pad.drive_val, 8'h0C);
	endtask
	// No clock edge between request and check
	task automatic t_ovr;
		req.pullup_override_en = 8'hF0;
		req.pullup_override_val = 8'hA0;
		req.dir_override_en = 8'h3C;
		req.dir_override_val = 8'h30;
		req.value_override_en = 8'h11;
		req.value_override_val = 8'h01;
		#1;
		cmp8(o_pad.pullup_en, 8'hAA);
		cmp8(o_pad.drive_en, 8'h33);
		cmp8(o_pad.drive_val, 8'h01);
		@(negedge i_sys_clk);
		req = '0;
	endtask
	task automatic t_toggle;
		req.toggle_override_en = 8'h81;
		repeat (3) @(negedge i_sys_clk);
		cmp8(o_pin_output_bit, 8'h4D);
		i_clk_en = 1'h0;
		repeat (2) @(negedge i_sys_clk);
		cmp8(o_pin_output_bit, 8'h4D);
		i_clk_en = 1'h1;
		req = '0;
	endtask
	task automatic t_input;
		i_pad_in = 8'hFF;
		i_sleep_clamp = 1'h1;
		req.input_en_override_en = 8'h0F;
		req.input_en_override_val = 8'h05;
		#1;
		cmp8(o_pin_digital_en, 8'h05);
		cmp8(o_pin_change_src, 8'h05);
		cmp8(o_pin_digital_in, 8'h05);
		// Port read path still lags the raw input
		cmp8(o_pin_read, 8'h00);
		@(negedge i_sys_clk);
		i_sleep_clamp = 1'h0;
		for (int k = 0; k < 4 && seen !== 8'hF5; k++)
			@(negedge i_sys_clk);
		cmp8(seen, 8'hF5);
		cmp8(o_pin_read, 8'hF5);
		req = '0;
		if (seen !== 8'hF5)
			stop_test;
	endtask
	task automatic t_route(input logic [7:0] p);
		i_pad_in = p;
		#1;
		cmp_route({o_spi_sck_def_in,
			o_spi_miso_def_in, o_spi_mosi_def_in, o_spi_ss_def_in,
			o_spi_miso_alt_in, o_spi_mosi_alt_in, o_spi_ss_alt_in,
			o_spi_sck_alt_in, o_serial0_rx, o_serial0_xfer_clk,
			o_serial1_rx, o_serial1_xfer_clk, o_i2c_scl_in, o_i2c_sda_in,
			o_timer0_ext_clk, o_timer1_ext_clk, o_timer2_ext_clk,
			o_capture_input},
			{p[4], p[5], p[6], p[7], p[0], p[1], p[2], p[3], p[2], p[3],
			p[4], p[6], p[4], p[6], p[3], p[4], p[5], p[7]});
		@(negedge i_sys_clk);
	endtask
	// Second reset mid-run clears registers and read path
	task automatic t_midreset;
		i_sys_rst = 1'h1;
		@(negedge i_sys_clk);
		i_sys_rst = 1'h0;
		t_reset;
		cmp8(o_pin_output_bit, 8'h00);
		cmp8(o_pin_read, 8'h00);
	endtask

	initial begin
		{mismatches, cmp_count} = '0;
		{i_sys_rst, i_clk_en, i_sleep_clamp} = 3'h6;
		{i_regwr, req, i_pad_in} = '0;
		repeat (4) @(negedge i_sys_clk);
		i_sys_rst = 1'h0;
		t_reset;
		t_regs;
		t_ovr;
		t_toggle;
		t_input;
		t_route(8'hA5);
		t_route(8'h5A);
		t_midreset;
		stop_test;
	end
	initial begin
		#200us;
		mismatches++;
		stop_test;
	end
endmodule
